// >>> core/pgw_pkg.sv
/*
 * constants and carriers for the password guarded watchdog block.
 * assumes a cpu bus that presents word writes with a word flag and
 * byte reads at the low 16 bits of the address.
 */
// Overview of operation
// - 8-bit counter counts prescaled ticks when enabled
// - rollover ff to 00 sets overflow flag
// - counter zero on reset and while disabled
// - overflow clears by read one then write zero
// - bit 6 picks interrupt or watchdog reset
// - bit 5 runs counter, resets to zero
// - clock select picks one of eight divisors
// - standby clears bits 7-5, keeps clock select
// - watchdog overflow sets watchdog reset flag
// - flag clears by pin reset or read-write
// - of the resets, only the pin clears flag and output enable
// - output enable lets reset drive pin low
// - reset control bits 5-0 read one
// - registers written only by word transfers
// - shared word address, keys 5a and a5
// - key a5 with data 00 clears flag
// - key 5a copies bit 6 to enable
// - byte reads at ffa8, ffa9, ffab
// - internal reset 518, pin reset 132 states
// - interval mode interrupt while overflow flag set
// - counter write beats coincident tick
// - own reset clears overflow, keeps flag
package pgw_pkg;
    localparam logic [15:0] ADDR_CSR_W   = 16'hffa8;
    localparam logic [15:0] ADDR_CSR_R   = 16'hffa8;
    localparam logic [15:0] ADDR_CNT_R   = 16'hffa9;
    localparam logic [15:0] ADDR_RCC_W   = 16'hffaa;
    localparam logic [15:0] ADDR_RCC_R   = 16'hffab;
    localparam logic [7:0]  KEY_CNT      = 8'h5a;
    localparam logic [7:0]  KEY_CSR      = 8'ha5;
    localparam logic [7:0]  KEY_RCC_CLR  = 8'ha5;
    localparam logic [7:0]  KEY_RCC_OE   = 8'h5a;
    localparam logic [7:0]  RCC_CLR_DATA = 8'h00;
    localparam int          BIT_OVER     = 7;
    localparam int          BIT_MODE     = 6;
    localparam int          BIT_RUN      = 5;
    localparam int          BIT_WDR      = 7;
    localparam int          BIT_ROE      = 6;
    localparam logic [7:0]  CNT_RESET    = 8'h00;
    localparam logic [7:0]  CNT_MAX      = 8'hff;
    localparam logic [1:0]  CSR_ONES     = 2'h3;
    localparam logic [5:0]  RCC_ONES     = 6'h3f;
    localparam logic [2:0]  CSEL_RESET   = 3'h0;
    // reset hold lengths, in system clock states
    localparam int          INT_RST_STATES = 518;
    localparam int          PIN_RST_STATES = 132;
    localparam int          CLK_PERIOD_NS  = 50;
    localparam int          STATE_NS       = 50;
    localparam int INT_RST_CYC = (INT_RST_STATES*STATE_NS+CLK_PERIOD_NS-1)
                                 / CLK_PERIOD_NS;
    localparam int PIN_RST_CYC = (PIN_RST_STATES*STATE_NS+CLK_PERIOD_NS-1)
                                 / CLK_PERIOD_NS;
    localparam int PRE_W = 12;

    typedef struct packed {
        logic        wr;
        logic        word;
        logic        rd;
        logic [15:0] addr;
        logic [15:0] wdata;
    } pgw_bus_s;

    typedef enum logic [1:0] {
        PGW_RUN  = 2'b00,
        PGW_HOLD = 2'b01
    } pgw_rst_e;
endpackage : pgw_pkg

// >>> core/pgw_top.sv
/*
 * watchdog / interval timer with password protected registers.
 * assumes bus signals are synchronous to clk_sys_i, and that reset_i
 * is the external reset pin; chip standby comes in on standby_i.
 */
`timescale 1ns/1ns
module pgw_top (
    input  wire logic              clk_sys_i,
    input  wire logic              reset_i,
    input  wire logic              standby_i,
    input  wire pgw_pkg::pgw_bus_s bus_i,
    output logic [7:0]             rdata_o,
    output logic                   interval_interrupt_o,
    output logic                   chip_reset_o,
    output logic                   reset_output_pin_n_o
);
    // ****************************************************************
    // register state
    // ****************************************************************
    logic [7:0]  watchdog_count;
    logic        overflow_flag;
    logic        mode_select_bit;
    logic        timer_enable_bit;
    logic [2:0]  clock_select_field;
    logic        watchdog_reset_flag;
    logic        reset_output_enable;
    logic        over_read;
    logic        wdr_read;
    logic [11:0] prescale;
    logic [11:0] prescale_d;
    logic [9:0]  hold_cnt;
    pgw_pkg::pgw_rst_e rst_state;

    // ****************************************************************
    // decode
    // ****************************************************************
    // byte writes fall out here, so they never touch a register
    wire       word_wr  = bus_i.wr & bus_i.word;
    wire [7:0] key      = bus_i.wdata[15:8];
    wire [7:0] wlow     = bus_i.wdata[7:0];
    wire       at_csr   = word_wr & (bus_i.addr == pgw_pkg::ADDR_CSR_W);
    wire       at_rcc   = word_wr & (bus_i.addr == pgw_pkg::ADDR_RCC_W);
    // unknown keys match nothing and are dropped
    wire       wr_cnt   = at_csr & (key == pgw_pkg::KEY_CNT);
    wire       wr_csr   = at_csr & (key == pgw_pkg::KEY_CSR);
    wire       wr_rclr  = at_rcc & (key == pgw_pkg::KEY_RCC_CLR)
                          & (wlow == pgw_pkg::RCC_CLR_DATA);
    wire       wr_roe   = at_rcc & (key == pgw_pkg::KEY_RCC_OE);
    wire       rd_csr   = bus_i.rd & (bus_i.addr == pgw_pkg::ADDR_CSR_R);
    wire       rd_cnt   = bus_i.rd & (bus_i.addr == pgw_pkg::ADDR_CNT_R);
    wire       rd_rcc   = bus_i.rd & (bus_i.addr == pgw_pkg::ADDR_RCC_R);
    // watchdog internal reset and standby wipe the control bits
    wire       soft_rst = chip_reset_o | standby_i;

    wire [7:0] csr_view = {overflow_flag, mode_select_bit, timer_enable_bit,
                           pgw_pkg::CSR_ONES, clock_select_field};
    wire [7:0] rcc_view = {watchdog_reset_flag, reset_output_enable,
                           pgw_pkg::RCC_ONES};
    wire [7:0] next_rdata = rd_csr ? csr_view :
                            rd_cnt ? watchdog_count :
                            rd_rcc ? rcc_view : 8'h00;

    // ****************************************************************
    // prescaler
    // ****************************************************************
    // tick on each rising edge of the chosen divider bit
    wire [3:0] tap = (clock_select_field == 3'h0) ? 4'd0 :
                     (clock_select_field == 3'h1) ? 4'd4 :
                     (clock_select_field == 3'h2) ? 4'd5 :
                     (clock_select_field == 3'h3) ? 4'd6 :
                     (clock_select_field == 3'h4) ? 4'd7 :
                     (clock_select_field == 3'h5) ? 4'd8 :
                     (clock_select_field == 3'h6) ? 4'd10 : 4'd11;
    wire tick = prescale[tap] & ~prescale_d[tap];
    wire run  = timer_enable_bit & ~soft_rst;
    wire roll = run & tick & ~wr_cnt
                & (watchdog_count == pgw_pkg::CNT_MAX);
    wire wd_fire = roll & mode_select_bit & (rst_state == pgw_pkg::PGW_RUN);

    // divider counts while the counter runs; cleared to zero with it to keep phase clean
    always_ff @(posedge clk_sys_i or posedge reset_i) begin
        if (reset_i) begin
            prescale   <= 12'h000;
            prescale_d <= 12'h000;
        end else begin
            prescale   <= run ? prescale + 12'h001 : 12'h000;
            prescale_d <= run ? prescale : 12'h000;
        end
    end

    // ****************************************************************
    // counter
    // ****************************************************************
    always_ff @(posedge clk_sys_i or posedge reset_i) begin
        if (reset_i) begin
            watchdog_count <= pgw_pkg::CNT_RESET;
        end else if (!run) begin
            watchdog_count <= pgw_pkg::CNT_RESET;
        end else if (wr_cnt) begin
            watchdog_count <= wlow;
        end else if (tick) begin
            watchdog_count <= watchdog_count + 8'h01;
        end
    end

    // ****************************************************************
    // control / status
    // ****************************************************************
    // the flag only clears after it was read as one; set beats clear
    always_ff @(posedge clk_sys_i or posedge reset_i) begin
        if (reset_i) begin
            overflow_flag    <= 1'b0;
            mode_select_bit  <= 1'b0;
            timer_enable_bit <= 1'b0;
            over_read        <= 1'b0;
        end else if (soft_rst) begin
            overflow_flag    <= 1'b0;
            mode_select_bit  <= 1'b0;
            timer_enable_bit <= 1'b0;
            over_read        <= 1'b0;
        end else begin
            if (roll) begin
                overflow_flag <= 1'b1;
            end else if (wr_csr & over_read & ~wlow[pgw_pkg::BIT_OVER]) begin
                overflow_flag <= 1'b0;
            end
            if (rd_csr & overflow_flag) begin
                over_read <= 1'b1;
            end else if (wr_csr | ~overflow_flag) begin
                over_read <= 1'b0;
            end
            if (wr_csr) begin
                mode_select_bit  <= wlow[pgw_pkg::BIT_MODE];
                timer_enable_bit <= wlow[pgw_pkg::BIT_RUN];
            end
        end
    end

    // clock select survives standby and watchdog reset, not the pin
    always_ff @(posedge clk_sys_i or posedge reset_i) begin
        if (reset_i) begin
            clock_select_field <= pgw_pkg::CSEL_RESET;
        end else if (wr_csr & ~soft_rst) begin
            clock_select_field <= wlow[2:0];
        end
    end

    // ****************************************************************
    // reset cause register
    // ****************************************************************
    // of the resets only the pin reset clears these; the watchdog reset does not
    always_ff @(posedge clk_sys_i or posedge reset_i) begin
        if (reset_i) begin
            watchdog_reset_flag <= 1'b0;
            reset_output_enable <= 1'b0;
            wdr_read            <= 1'b0;
        end else begin
            if (wd_fire) begin
                watchdog_reset_flag <= 1'b1;
            end else if (wr_rclr & wdr_read) begin
                watchdog_reset_flag <= 1'b0;
            end
            if (rd_rcc & watchdog_reset_flag) begin
                wdr_read <= 1'b1;
            end else if (wr_rclr | ~watchdog_reset_flag) begin
                wdr_read <= 1'b0;
            end
            if (wr_roe) begin
                reset_output_enable <= wlow[pgw_pkg::BIT_ROE];
            end
        end
    end

    // ****************************************************************
    // reset pulse generator
    // ****************************************************************
    always_ff @(posedge clk_sys_i or posedge reset_i) begin
        if (reset_i) begin
            rst_state            <= pgw_pkg::PGW_RUN;
            hold_cnt             <= 10'h000;
            chip_reset_o         <= 1'b0;
            reset_output_pin_n_o <= 1'b1;
        end else begin
            case (rst_state)
                pgw_pkg::PGW_RUN: begin
                    if (wd_fire) begin
                        rst_state            <= pgw_pkg::PGW_HOLD;
                        hold_cnt             <= 10'h000;
                        chip_reset_o         <= 1'b1;
                        reset_output_pin_n_o <= ~reset_output_enable;
                    end
                end
                pgw_pkg::PGW_HOLD: begin
                    hold_cnt <= hold_cnt + 10'h001;
                    if (hold_cnt == 10'(pgw_pkg::PIN_RST_CYC - 1)) begin
                        reset_output_pin_n_o <= 1'b1;
                    end
                    if (hold_cnt == 10'(pgw_pkg::INT_RST_CYC - 1)) begin
                        chip_reset_o <= 1'b0;
                        rst_state    <= pgw_pkg::PGW_RUN;
                    end
                end
                default: rst_state <= pgw_pkg::PGW_RUN;
            endcase
        end
    end

    // ****************************************************************
    // outputs
    // ****************************************************************
    always_ff @(posedge clk_sys_i or posedge reset_i) begin
        if (reset_i) begin
            rdata_o              <= 8'h00;
            interval_interrupt_o <= 1'b0;
        end else begin
            rdata_o              <= next_rdata;
            // level request while the flag stands in interval mode
            interval_interrupt_o <= (overflow_flag | roll)
                                    & ~mode_select_bit & ~soft_rst;
        end
    end

    // ****************************************************************
    // assertions
    // ****************************************************************
    // one clock domain here, so clock and reset are stated only once
    default clocking cb_chk @(posedge clk_sys_i);
    endclocking
    default disable iff (reset_i);

    // run lengths of both reset outputs; the long windows are judged
    // on these counters, since unrolling hundreds of delays is slow
    logic [9:0] chip_len;
    logic [9:0] pin_len;
    always_ff @(posedge clk_sys_i or posedge reset_i) begin
        if (reset_i) begin
            chip_len <= 10'h000;
            pin_len  <= 10'h000;
        end else begin
            chip_len <= chip_reset_o ? chip_len + 10'h001 : 10'h000;
            pin_len  <= reset_output_pin_n_o ? 10'h000 : pin_len + 10'h001;
        end
    end

    sequence s_fire;
        wd_fire;
    endsequence
    sequence s_hold_pin;
        !reset_output_pin_n_o [*8];
    endsequence
    sequence s_hold_chip;
        chip_reset_o [*8];
    endsequence

    a_roll_sets_flag: assert property (
        roll && !soft_rst |=> overflow_flag)
        else $error("overflow flag not set on rollover");
    a_tick_counts: assert property (
        run && tick && !wr_cnt |=>
        watchdog_count == $past(watchdog_count) + 8'h01)
        else $error("counter did not step on a tick");
    a_disable_zeros: assert property (
        !timer_enable_bit |=> watchdog_count == 8'h00)
        else $error("counter not held at zero");
    a_byte_write_ignored: assert property (
        bus_i.wr && !bus_i.word && !tick && !soft_rst |=>
        $stable(watchdog_count))
        else $error("byte write changed counter");
    a_write_beats_tick: assert property (
        wr_cnt && run |=> watchdog_count == $past(wlow))
        else $error("counter write lost to tick");
    a_irq_follows_flag: assert property (
        overflow_flag && !mode_select_bit && !soft_rst |=>
        interval_interrupt_o)
        else $error("interval request missing");
    a_irq_quiet_wd: assert property (
        mode_select_bit |=> !interval_interrupt_o)
        else $error("interval request in watchdog mode");
    a_interval_no_reset: assert property (
        roll && !mode_select_bit |=> !chip_reset_o)
        else $error("reset raised in interval mode");
    a_fire_sets_cause: assert property (
        s_fire |=> watchdog_reset_flag && chip_reset_o)
        else $error("watchdog reset not flagged");
    a_cause_clear: assert property (
        wr_rclr && wdr_read && !wd_fire |=> !watchdog_reset_flag)
        else $error("reset cause flag not cleared");
    a_pin_pulse_len: assert property (
        (s_fire and reset_output_enable) |=> s_hold_pin ##124
        !reset_output_pin_n_o ##1 reset_output_pin_n_o)
        else $error("reset pin pulse length wrong");
    a_chip_rst_len: assert property (
        s_fire |=> s_hold_chip ##255 chip_reset_o ##255 chip_reset_o
        ##1 !chip_reset_o)
        else $error("internal reset length wrong");
    a_chip_rst_count: assert property (
        $fell(chip_reset_o) |->
        chip_len == 10'(pgw_pkg::INT_RST_STATES))
        else $error("internal reset run length wrong");
    a_pin_rst_count: assert property (
        $rose(reset_output_pin_n_o) |->
        pin_len == 10'(pgw_pkg::PIN_RST_STATES))
        else $error("reset pin run length wrong");
    a_pin_quiet_off: assert property (
        (s_fire and !reset_output_enable) |=> reset_output_pin_n_o [*4])
        else $error("pin driven with output disabled");
    a_cause_survives: assert property (
        chip_reset_o && watchdog_reset_flag && !wr_rclr |=>
        watchdog_reset_flag && !overflow_flag)
        else $error("own reset changed cause flags");
    a_bad_key_ignored: assert property (
        at_csr && key != 8'h5a && key != 8'ha5 && !soft_rst && !run |=>
        $stable(mode_select_bit) && $stable(clock_select_field))
        else $error("wrong key changed register");
endmodule : pgw_top

// >>> tb/tb_top.sv
/*
 * self-checking bench for the password guarded watchdog top.
 * assumes the bench drives every input at the falling clock edge and
 * samples registered outputs there; no partner model is needed.
 */
`timescale 1ns/1ns
module tb_top;
    logic              clk_sys_i;
    logic              reset_i;
    logic              standby_i;
    pgw_pkg::pgw_bus_s bus_i;
    logic [7:0]        rdata_o;
    logic              interval_interrupt_o;
    logic              chip_reset_o;
    logic              reset_output_pin_n_o;
    int                n_fail;
    int                comparisons;
    int                cycles;

    pgw_top dut (
        .clk_sys_i            (clk_sys_i),
        .reset_i              (reset_i),
        .standby_i            (standby_i),
        .bus_i                (bus_i),
        .rdata_o              (rdata_o),
        .interval_interrupt_o (interval_interrupt_o),
        .chip_reset_o         (chip_reset_o),
        .reset_output_pin_n_o (reset_output_pin_n_o)
    );

    // ****************************************
    // clock, watchdog on the bench itself
    // ****************************************
    initial begin
        clk_sys_i = 1'b0;
        forever #25 clk_sys_i = ~clk_sys_i;
    end

    // ceiling is several times the longest expected run
    always @(posedge clk_sys_i) begin
        cycles++;
        if (cycles == 30000) begin
            n_fail++;
            $display("FAIL at %0t ns: run timed out", $time);
            give_verdict();
        end
    end

    // ****************************************
    // shared bus and compare tasks
    // ****************************************
    task automatic check(input logic [15:0] got, input logic [15:0] exp,
                         input string what);
        comparisons++;
        if (got !== exp) begin
            n_fail++;
            $display("FAIL at %0t ns: %s got %h want %h", $time, what, got,
                     exp);
        end
    endtask : check

    // request held one full cycle, released a falling edge later
    task automatic bus_write(input logic [15:0] addr, input logic word,
                             input logic [15:0] data);
        @(negedge clk_sys_i);
        bus_i.wr = 1'b1;
        bus_i.word = word;
        bus_i.addr = addr;
        bus_i.wdata = data;
        @(negedge clk_sys_i);
        bus_i = '0;
    endtask : bus_write

    // read data stands for the cycle after the read edge
    task automatic bus_read(input logic [15:0] addr, input logic [7:0] exp,
                            input string what);
        @(negedge clk_sys_i);
        bus_i.rd = 1'b1;
        bus_i.addr = addr;
        @(negedge clk_sys_i);
        bus_i = '0;
        check({8'h00, rdata_o}, {8'h00, exp}, what);
    endtask : bus_read

    task automatic pin_reset();
        @(negedge clk_sys_i);
        reset_i = 1'b1;
        @(negedge clk_sys_i);
        reset_i = 1'b0;
    endtask : pin_reset

    // ****************************************
    // scenarios
    // ****************************************
    task automatic t_reset_view();
        bus_read(pgw_pkg::ADDR_CSR_R, 8'h18, "ctrl reset");
        bus_read(pgw_pkg::ADDR_CNT_R, 8'h00, "count reset");
        bus_read(pgw_pkg::ADDR_RCC_R, 8'h3f, "rcc reset");
        $display("test reset_view done");
    endtask : t_reset_view

    task automatic t_write_guard();
        bus_write(pgw_pkg::ADDR_CSR_W, 1'b0, 16'ha527);
        bus_read(pgw_pkg::ADDR_CSR_R, 8'h18, "byte write");
        bus_write(pgw_pkg::ADDR_CSR_W, 1'b1, 16'h3327);
        bus_read(pgw_pkg::ADDR_CSR_R, 8'h18, "bad key");
        // slowest divisor so the loaded count cannot move before the read
        bus_write(pgw_pkg::ADDR_CSR_W, 1'b1, 16'ha5ff);
        bus_read(pgw_pkg::ADDR_CSR_R, 8'h7f, "ctrl load");
        bus_write(pgw_pkg::ADDR_CSR_W, 1'b1, 16'h5a42);
        bus_read(pgw_pkg::ADDR_CNT_R, 8'h42, "count load");
        bus_write(pgw_pkg::ADDR_CSR_W, 1'b1, 16'ha500);
        bus_read(pgw_pkg::ADDR_CNT_R, 8'h00, "count cleared");
        $display("test write_guard done");
    endtask : t_write_guard

    task automatic t_interval();
        bus_write(pgw_pkg::ADDR_CSR_W, 1'b1, 16'ha520);
        bus_write(pgw_pkg::ADDR_CSR_W, 1'b1, 16'h5afd);
        for (int i = 0; i < 100; i++) begin
            @(negedge clk_sys_i);
            if (interval_interrupt_o === 1'b1) break;
        end
        check(16'(interval_interrupt_o), 16'h1, "irq");
        check(16'(chip_reset_o), 16'h0, "no reset");
        // zero written with no prior read must not clear the flag
        bus_write(pgw_pkg::ADDR_CSR_W, 1'b1, 16'ha520);
        bus_read(pgw_pkg::ADDR_CSR_R, 8'hb8, "flag held");
        bus_write(pgw_pkg::ADDR_CSR_W, 1'b1, 16'ha500);
        bus_read(pgw_pkg::ADDR_CSR_R, 8'h18, "flag cleared");
        check(16'(interval_interrupt_o), 16'h0, "irq drop");
        $display("test interval done");
    endtask : t_interval

    // watchdog overflow, measuring both reset lengths
    task automatic wd_trip(input logic oe);
        int n_rst;
        int n_pin;
        n_rst = 0;
        n_pin = 0;
        bus_write(pgw_pkg::ADDR_RCC_W, 1'b1, {pgw_pkg::KEY_RCC_OE,
                  1'b0, oe, 6'h00});
        bus_read(pgw_pkg::ADDR_RCC_R, {1'b0, oe, 6'h3f}, "oe");
        bus_write(pgw_pkg::ADDR_CSR_W, 1'b1, 16'ha561);
        bus_write(pgw_pkg::ADDR_CSR_W, 1'b1, 16'h5afd);
        for (int i = 0; i < 1200; i++) begin
            @(negedge clk_sys_i);
            if (chip_reset_o === 1'b1) n_rst++;
            if (reset_output_pin_n_o === 1'b0) n_pin++;
            if (n_rst > 0 && chip_reset_o !== 1'b1) break;
        end
        check(16'(n_rst), 16'd518, "int reset len");
        check(16'(n_pin), oe ? 16'd132 : 16'd0, "pin len");
        bus_read(pgw_pkg::ADDR_RCC_R, {1'b1, oe, 6'h3f},
                 "flag");
        bus_read(pgw_pkg::ADDR_CSR_R, 8'h19, "ctrl after");
        bus_read(pgw_pkg::ADDR_CNT_R, 8'h00, "count after");
    endtask : wd_trip

    task automatic t_wd_clear();
        wd_trip(1'b1);
        bus_write(pgw_pkg::ADDR_RCC_W, 1'b0, 16'ha500);
        bus_read(pgw_pkg::ADDR_RCC_R, 8'hff, "byte clr");
        bus_write(pgw_pkg::ADDR_RCC_W, 1'b1, 16'ha500);
        bus_read(pgw_pkg::ADDR_RCC_R, 8'h7f, "flag clr");
        $display("test wd_clear done");
    endtask : t_wd_clear

    task automatic t_wd_pin();
        wd_trip(1'b0);
        pin_reset();
        bus_read(pgw_pkg::ADDR_RCC_R, 8'h3f, "pin clr");
        bus_read(pgw_pkg::ADDR_CSR_R, 8'h18, "pin ctrl");
        $display("test wd_pin done");
    endtask : t_wd_pin

    task automatic t_standby();
        bus_write(pgw_pkg::ADDR_CSR_W, 1'b1, 16'ha527);
        @(negedge clk_sys_i);
        standby_i = 1'b1;
        @(negedge clk_sys_i);
        standby_i = 1'b0;
        bus_read(pgw_pkg::ADDR_CSR_R, 8'h1f, "standby");
        bus_read(pgw_pkg::ADDR_CNT_R, 8'h00, "standby cnt");
        $display("test standby done");
    endtask : t_standby

    // ****************************************
    // verdict and main sequence
    // ****************************************
    task automatic give_verdict();
        $display("comparisons %0d, mismatches %0d", comparisons, n_fail);
        if (n_fail == 0 && comparisons > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : give_verdict

    initial begin
        n_fail = 0;
        comparisons = 0;
        cycles = 0;
        reset_i = 1'b1;
        standby_i = 1'b0;
        bus_i = '0;
        repeat (6) @(negedge clk_sys_i);
        reset_i = 1'b0;
        t_reset_view();
        t_write_guard();
        t_interval();
        t_wd_clear();
        t_wd_pin();
        t_standby();
        give_verdict();
    end
endmodule : tb_top
